// *** csc_pkg.sv ***
// Shared constants and types for the clock supervisor counter.
// Assumes a 32-bit classic Wishbone bus with byte addresses.
package csc_pkg;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam int ADR_W = 16;
   localparam logic [11:0] CTRL_IDX = 12'hFE9;
   localparam logic [11:0] DATA_IDX = 12'hFEA;
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] DATA_RST = 8'h00;

   // ----------------------------------------------------------------
   // Control field positions
   // ----------------------------------------------------------------
   localparam int EN_BIT = 0;
   localparam int SEL_LSB = 1;
   localparam int SEL_W = 3;
   localparam int SRC_BIT = 4;
   localparam int RSV_BIT = 5;
   localparam int N_TAPS = 8;
   localparam int CNT_W = 8;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic reserved;
      logic count_source_select;
      logic [2:0] gate_interval_select;
      logic measure_enable;
   } csc_ctrl_t;

   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_ARM = 4'b0010,
      ST_COUNT = 4'b0100,
      ST_CLOSE = 4'b1000
   } csc_state_t;

endpackage

// *** csc_sync_edge.sv ***
// Two-stage synchroniser with rise and fall detection per bit.
// Assumes its inputs are asynchronous to clk_i and slower than half its rate.
`timescale 1ns/1ps
module csc_sync_edge #(
   parameter int WIDTH = 1
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [WIDTH-1:0] d_i,
   output logic [WIDTH-1:0] lvl_o,
   output logic [WIDTH-1:0] rise_o,
   output logic [WIDTH-1:0] fall_o
);
   logic [WIDTH-1:0] s1_q;
   logic [WIDTH-1:0] s2_q;
   logic [WIDTH-1:0] s3_q;

   initial begin
      if (WIDTH < 1) $error("csc_sync_edge: WIDTH must be at least 1.");
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
      end else begin
         s1_q <= d_i;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   assign lvl_o = s2_q;
   assign rise_o = s2_q & ~s3_q;
   assign fall_o = ~s2_q & s3_q;
endmodule // csc_sync_edge

// *** csc_sat_counter.sv ***
// Saturating up counter with synchronous clear.
// Assumes clear and increment come from logic on the same clock.
`timescale 1ns/1ps
module csc_sat_counter #(
   parameter int WIDTH = 8
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic clr_i,
   input wire logic inc_i,
   output logic [WIDTH-1:0] cnt_o,
   output logic sat_o
);
   logic [WIDTH-1:0] cnt_q;

   initial begin
      if (WIDTH < 2) $error("csc_sat_counter: WIDTH must be at least 2.");
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || clr_i) begin
         cnt_q <= '0;
      end else if (inc_i && !(&cnt_q)) begin
         cnt_q <= cnt_q + {{(WIDTH-1){1'b0}}, 1'b1};
      end
   end

   assign cnt_o = cnt_q;
   assign sat_o = &cnt_q;
endmodule // csc_sat_counter

// *** csc_top.sv ***
// Clock supervisor counter: counts edges of a chosen oscillator in a time-base gate window.
// Assumes tap and oscillator inputs arrive asynchronously and a classic Wishbone master.
//
// Notes on behaviour
// - Setting enable starts gating with one of eight taps picked by a 3-bit field.
// - Counter advances on oscillator edges only between two tap rising edges.
// - Software picks main or sub oscillator as the counted clock.
// - Captured count is cleared when enable goes from 0 to 1.
// - Counter stops at 255 and never wraps.
// - A dead oscillator gives no edges, so the counter stops advancing.
// - Clearing enable mid-measurement aborts and zeroes the counter.
// - Counting halts while the time-base timer is stopped.
// - Captured count reads zero while enable is one.
// - After a late oscillator restart, enable clears once the oscillator edge arrives.
// - Dead oscillator: enable and counter clear at tap falling edge after second rise.
// - Counting starts at the first tap rise after enabling, stops at the second.
// - Enable clears by itself when the window ends.
// - Codes 000 to 111 select taps of 2^3, 2^5 up to 2^17 CR periods.
// - Source select 0 picks main oscillator, 1 picks sub oscillator.
`timescale 1ns/1ps
module csc_top #(
   parameter int CNT_W = csc_pkg::CNT_W
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [csc_pkg::ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [csc_pkg::N_TAPS-1:0] tb_taps_i,
   input wire logic tb_running_i,
   input wire logic main_osc_i,
   input wire logic sub_osc_i,
   output logic measure_enable_o,
   output logic measuring_o
);

   // ----------------------------------------------------------------
   // Elaboration checks
   // ----------------------------------------------------------------
   initial begin
      if (CNT_W != 8) $error("csc_top: the captured register holds exactly 8 bits.");
      if ((1 << csc_pkg::SEL_W) != csc_pkg::N_TAPS) begin
         $error("csc_top: the interval field must reach every tap.");
      end
      if ($bits(csc_pkg::csc_ctrl_t) != csc_pkg::RSV_BIT + 1) begin
         $error("csc_top: the control word must end at the reserved bit.");
      end
      if (csc_pkg::SRC_BIT != csc_pkg::SEL_LSB + csc_pkg::SEL_W) begin
         $error("csc_top: the source bit must follow the interval field.");
      end
      if (csc_pkg::EN_BIT != 0) begin
         $error("csc_top: the enable bit must sit at bit 0.");
      end
   end

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   // The printed offsets are word indices; the byte address is four times the index.
   function automatic logic reg_hit(input logic [csc_pkg::ADR_W-1:0] adr, input logic [11:0] idx);
      logic [csc_pkg::ADR_W-1:0] base;
      base = {2'b00, idx, 2'b00};
      reg_hit = (adr[csc_pkg::ADR_W-1:2] == base[csc_pkg::ADR_W-1:2]);
   endfunction

   logic req;
   logic hit_ctrl;
   logic hit_data;
   logic wr_ctrl;

   assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign hit_ctrl = reg_hit(wb_adr_i, csc_pkg::CTRL_IDX);
   assign hit_data = reg_hit(wb_adr_i, csc_pkg::DATA_IDX);
   assign wr_ctrl = req && wb_we_i && hit_ctrl && wb_sel_i[0];

   // ----------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------
   logic [csc_pkg::N_TAPS-1:0] tap_rise;
   logic [csc_pkg::N_TAPS-1:0] tap_fall;
   logic [2:0] osc_lvl;
   logic [2:0] osc_rise;

   csc_sync_edge #(.WIDTH(csc_pkg::N_TAPS)) u_tap_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .d_i(tb_taps_i),
      .lvl_o(),
      .rise_o(tap_rise),
      .fall_o(tap_fall)
   );

   csc_sync_edge #(.WIDTH(3)) u_osc_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .d_i({tb_running_i, sub_osc_i, main_osc_i}),
      .lvl_o(osc_lvl),
      .rise_o(osc_rise),
      .fall_o()
   );

   // ----------------------------------------------------------------
   // Control register
   // ----------------------------------------------------------------
   csc_pkg::csc_ctrl_t ctrl_q;
   csc_pkg::csc_state_t state_q;
   logic end_ok;
   logic end_dead;
   logic start;
   logic abort;
   logic tb_run;
   logic en_clr;

   assign tb_run = osc_lvl[2];
   assign start = wr_ctrl && wb_dat_i[csc_pkg::EN_BIT] && !ctrl_q.measure_enable;
   assign abort = wr_ctrl && !wb_dat_i[csc_pkg::EN_BIT] && ctrl_q.measure_enable;
   assign en_clr = abort || end_ok || end_dead;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_q <= csc_pkg::csc_ctrl_t'(csc_pkg::CTRL_RST[5:0]);
      end else begin
         if (wr_ctrl) begin
            ctrl_q.reserved <= wb_dat_i[csc_pkg::RSV_BIT];
            ctrl_q.count_source_select <= wb_dat_i[csc_pkg::SRC_BIT];
            ctrl_q.gate_interval_select <= wb_dat_i[csc_pkg::SEL_LSB +: csc_pkg::SEL_W];
         end
         if (start) begin
            ctrl_q.measure_enable <= 1'b1;
         end else if (en_clr) begin
            ctrl_q.measure_enable <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Gate and source selection
   // ----------------------------------------------------------------
   logic gate_rise;
   logic gate_fall;
   logic src_rise;
   logic [csc_pkg::N_TAPS-1:0] tap_rise_run;
   logic [csc_pkg::N_TAPS-1:0] tap_fall_run;
   logic [csc_pkg::SEL_W-1:0] sel_now;
   logic src_now;
   logic en_now;

   assign sel_now = ctrl_q.gate_interval_select;
   assign src_now = ctrl_q.count_source_select;
   assign en_now = ctrl_q.measure_enable;

   // A stopped time base freezes every tap, so tap edges are trusted only while it runs.
   for (genvar g = 0; g < csc_pkg::N_TAPS; g++) begin : g_tap
      assign tap_rise_run[g] = tap_rise[g] && tb_run;
      assign tap_fall_run[g] = tap_fall[g] && tb_run;
   end

   // Tap i carries a period of 2^(3+2i) CR clocks; the time-base timer provides them.
   assign gate_rise = tap_rise_run[sel_now];
   assign gate_fall = tap_fall_run[sel_now];
   assign src_rise = src_now ? osc_rise[1] : osc_rise[0];

   // ----------------------------------------------------------------
   // Measurement sequencer
   // ----------------------------------------------------------------
   logic [CNT_W-1:0] cnt;
   logic cnt_inc;
   logic cnt_clr;
   logic in_close;
   logic in_count;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_q <= csc_pkg::ST_IDLE;
      end else if (abort) begin
         state_q <= csc_pkg::ST_IDLE;
      end else begin
         case (state_q)
            csc_pkg::ST_IDLE: begin
               if (start) begin
                  state_q <= csc_pkg::ST_ARM;
               end
            end
            csc_pkg::ST_ARM: begin
               if (gate_rise) begin
                  state_q <= csc_pkg::ST_COUNT;
               end
            end
            csc_pkg::ST_COUNT: begin
               if (gate_rise) begin
                  state_q <= csc_pkg::ST_CLOSE;
               end
            end
            csc_pkg::ST_CLOSE: begin
               if (src_rise || gate_fall) begin
                  state_q <= csc_pkg::ST_IDLE;
               end
            end
            default: begin
               state_q <= csc_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // The window is closed by the measured clock itself, or by the gate tap falling edge when that clock is dead.
   assign in_close = (state_q == csc_pkg::ST_CLOSE);
   assign in_count = (state_q == csc_pkg::ST_COUNT);
   assign end_ok = in_close && src_rise;
   assign end_dead = in_close && !src_rise && gate_fall;

   // A stopped oscillator yields no edges, which stalls the count on its own.
   assign cnt_inc = in_count && src_rise && !gate_rise && tb_run;
   assign cnt_clr = start || abort || end_dead;

   csc_sat_counter #(.WIDTH(CNT_W)) u_counter (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .clr_i(cnt_clr),
      .inc_i(cnt_inc),
      .cnt_o(cnt),
      .sat_o()
   );

   // ----------------------------------------------------------------
   // Captured count
   // ----------------------------------------------------------------
   logic [7:0] captured_count_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         captured_count_q <= csc_pkg::DATA_RST;
      end else if (start || abort || end_dead) begin
         captured_count_q <= 8'h00;
      end else if (end_ok) begin
         captured_count_q <= cnt;
      end
   end

   // ----------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------
   // The count is masked while a measurement runs, so an early read never sees a partial value.
   logic [7:0] rd_byte;

   always_comb begin
      rd_byte = 8'h00;
      if (hit_ctrl) begin
         rd_byte = {2'b00, ctrl_q};
      end else if (hit_data) begin
         rd_byte = en_now ? 8'h00 : captured_count_q;
      end
   end

   // ----------------------------------------------------------------
   // Bus answer
   // ----------------------------------------------------------------
   // Unmapped addresses are acknowledged with zero data so a stray access never hangs.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= req;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (req && !wb_we_i) begin
         wb_dat_o <= {24'h00_0000, rd_byte};
      end
   end

   // ----------------------------------------------------------------
   // Status outputs
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         measure_enable_o <= 1'b0;
      end else begin
         measure_enable_o <= en_now;
      end
   end

   // The window flag trails the state by one cycle so that it leaves a flip-flop.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         measuring_o <= 1'b0;
      end else begin
         measuring_o <= in_count;
      end
   end

endmodule // csc_top

// *** csc_monitor.sv ***
// Port checker for the clock supervisor counter.
// Assumes it is bound to csc_top and sees only that module's ports.
`timescale 1ns/1ps
module csc_monitor (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [csc_pkg::ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic tb_running_i,
   input wire logic measure_enable_o,
   input wire logic measuring_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic take;
   logic wr_ctl;
   logic rd_dat;
   assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wr_ctl = take && wb_we_i && wb_sel_i[0] && wb_adr_i[15:2] == {2'b00, csc_pkg::CTRL_IDX};
   assign rd_dat = take && !wb_we_i && wb_adr_i[15:2] == {2'b00, csc_pkg::DATA_IDX};
   a_ack_next: assert property (take |=> wb_ack_o) else $error("ack missing after request");
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
   a_busy_read_zero: assert property (rd_dat ##1 measure_enable_o |-> wb_dat_o[7:0] == 8'h00)
      else $error("count visible while enabled");
   a_start_sets: assert property (wr_ctl && wb_dat_i[0] && !measure_enable_o |-> ##[1:3] measure_enable_o)
      else $error("enable did not set");
   a_abort_clears: assert property (wr_ctl && !wb_dat_i[0] && measure_enable_o
      |-> ##[1:3] !measure_enable_o && !measuring_o) else $error("abort ignored");
   // The bound covers the short taps used here; a dead clock on a long tap waits longer.
   a_end_clears: assert property ($fell(measuring_o) |-> ##[0:400] !measure_enable_o)
      else $error("enable stuck after window");
   a_halt_stopped: assert property (!tb_running_i [*4] |-> !$rose(measuring_o))
      else $error("window opened while time base stopped");
   a_window_enabled: assert property ($rose(measuring_o) |-> measure_enable_o)
      else $error("window without enable");
   a_reset_quiet: assert property (disable iff (1'b0) rst_i |=> !wb_ack_o && !measure_enable_o && !measuring_o)
      else $error("outputs active after reset");
   c_start: cover property (wr_ctl && wb_dat_i[0]);
   c_window: cover property ($fell(measuring_o));
   c_abort: cover property (wr_ctl && !wb_dat_i[0] && measure_enable_o);
endmodule // csc_monitor

bind csc_top csc_monitor u_csc_monitor (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
   .wb_dat_i, .wb_dat_o, .wb_ack_o, .tb_running_i, .measure_enable_o, .measuring_o);

// *** csc_osc_model.sv ***
// Behavioural crystal oscillator measured by the clock supervisor.
// Assumes the bench starts and stops it through run_i.
`timescale 1ns/1ps
module csc_osc_model #(
   parameter int HALF_NS = 500
) (
   input wire logic run_i,
   output logic osc_o
);
   initial osc_o = 1'b0;
   // A stopped crystal parks low, which is what a dead oscillator looks like.
   always #HALF_NS osc_o = run_i ? ~osc_o : 1'b0;
endmodule // csc_osc_model

// *** tb_csc_top.sv ***
// Self-checking bench for the clock supervisor counter.
// Assumes a free-running time base made here and two oscillator models.
`timescale 1ns/1ps
module tb_csc_top;
   logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, run = 1'b1, main_run = 1'b1;
   logic [15:0] adr = 16'h0000;
   logic [31:0] wdat = 32'h00000000, rdat;
   logic ack, men, meas, main_osc, sub_osc;
   logic [7:0] taps, r, c;
   logic [16:0] timebase_interval_setting = 17'h00000;
   int errors = 0, n_checks = 0;
   localparam logic [15:0] CTL = {2'b00, csc_pkg::CTRL_IDX, 2'b00};
   localparam logic [15:0] DAT = {2'b00, csc_pkg::DATA_IDX, 2'b00};
   // Rows: source and interval code, then lowest and highest plausible count.
   // Codes 6 and 7 are left out: their windows would dominate the run time.
   localparam logic [19:0] ROWS [8] = '{20'h00002, 20'h10204, 20'h20B0E, 20'hA0609,
      20'h33135, 20'hB1E21, 20'h4CACF, 20'h5FFFF};
   always #50 clk_i = ~clk_i;
   always @(posedge clk_i) timebase_interval_setting <= timebase_interval_setting + 17'h00001;
   always_comb for (int i = 0; i < 8; i++) taps[i] = timebase_interval_setting[2 + 2 * i];
   csc_top u_csc_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .tb_taps_i(taps),
      .tb_running_i(run), .main_osc_i(main_osc), .sub_osc_i(sub_osc), .measure_enable_o(men), .measuring_o(meas));
   csc_osc_model #(.HALF_NS(500)) u_csc_osc_model (.run_i(main_run), .osc_o(main_osc));
   csc_osc_model #(.HALF_NS(800)) u_csc_osc_model_sub (.run_i(1'b1), .osc_o(sub_osc));
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic chk_rng(input string what, input logic [7:0] lo, input logic [7:0] hi, input logic [7:0] got);
      n_checks++;
      if ((got >= lo && got <= hi) !== 1'b1) begin
         errors++;
         $display("MISMATCH %s expected %0d to %0d seen %h", what, lo, hi, got);
      end
   endtask
   task automatic wb(input logic w, input logic [15:0] a, input logic [7:0] d);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= {24'h000000, d};
      do @(posedge clk_i); while (ack !== 1'b1);
      r = rdat[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic finish(output logic [7:0] cnt);
      do wb(1'b0, CTL, 8'h00); while (r[0] !== 1'b0);
      wb(1'b0, DAT, 8'h00);
      cnt = r;
   endtask
   task automatic measure(input logic [3:0] ss, output logic [7:0] cnt);
      wb(1'b1, CTL, {3'b000, ss, 1'b1});
      wb(1'b0, DAT, 8'h00);
      chk("count while enabled", 8'h00, r);
      finish(cnt);
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      #8000000;
      errors++;
      conclude();
   end
   initial begin
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      chk("outputs in reset", 8'h00, {6'h00, men, meas});
      wb(1'b0, CTL, 8'h00);
      chk("control reset", csc_pkg::CTRL_RST, r);
      wb(1'b0, DAT, 8'h00);
      chk("count reset", csc_pkg::DATA_RST, r);
      $display("test reset done");
      for (int i = 0; i < 8; i++) begin
         measure(ROWS[i][19:16], c);
         chk_rng("window count", ROWS[i][15:8], ROWS[i][7:0], c);
      end
      $display("test table done");
      wb(1'b1, CTL, 8'hE0);
      wb(1'b0, CTL, 8'h00);
      chk("undefined bits", 8'h20, r);
      wb(1'b1, CTL, 8'h00);
      wb(1'b0, 16'h0010, 8'h00);
      chk("unmapped read", 8'h00, r);
      $display("test map done");
      wb(1'b1, CTL, 8'h09);
      while (meas !== 1'b1) @(posedge clk_i);
      repeat (100) @(posedge clk_i);
      wb(1'b1, CTL, 8'h08);
      wb(1'b0, DAT, 8'h00);
      chk("count after abort", 8'h00, r);
      chk("state after abort", 8'h00, {6'h00, men, meas});
      $display("test abort done");
      main_run <= 1'b0;
      measure(4'h2, c);
      chk("dead clock count", 8'h00, c);
      main_run <= 1'b1;
      $display("test dead clock done");
      run <= 1'b0;
      wb(1'b1, CTL, 8'h05);
      repeat (300) @(posedge clk_i);
      chk("time base halted", 8'h02, {6'h00, men, meas});
      run <= 1'b1;
      finish(c);
      chk_rng("count after resume", 8'h0B, 8'h0E, c);
      $display("test halt done");
      conclude();
   end
endmodule // tb_csc_top
